// ### common/antenna_pkg.sv
// Package: register map, field layouts and types for the antenna select and switch block
`default_nettype none
package antenna_pkg;
    localparam logic [15:0] idle_control_offset  = 16'h9910;
    localparam logic [15:0] table_one_offset     = 16'h9960;
    localparam logic [15:0] table_two_offset     = 16'h9964;
    localparam int          idle_entry_lsb       = 4;
    localparam int          entry_width          = 6;
    localparam int          slot_tx              = 0;
    localparam int          slot_rx_plain        = 1;
    localparam int          slot_rx_first        = 2;
    localparam int          slot_rx_second       = 3;
    localparam int          slot_rx_both         = 4;
    localparam logic [31:0] idle_control_reset   = 32'h0000_0000;
    localparam logic [31:0] table_reset          = 32'h0000_0000;
    localparam logic [3:0]  default_antenna_reset = 4'h1;
    localparam logic [3:0]  antenna_one          = 4'h1;
    localparam logic [3:0]  antenna_two          = 4'h2;
    localparam logic [3:0]  omni_antenna         = 4'h1;

    typedef enum logic [3:0] {
        st_listen = 4'b0001,
        st_tx     = 4'b0010,
        st_wait   = 4'b0100,
        st_rx     = 4'b1000
    } seq_state_type;

    typedef struct packed {
        logic       use_default_antenna;
        logic       update_default_antenna;
        logic       rts_on_default;
        logic       band_2g;
        logic       fast_diversity_enable;
    } mode_bits_type;

    typedef struct packed {
        logic       tx_start;
        logic       tx_is_rts;
        logic       tx_directed;
        logic       tx_is_ack;
        logic       tx_done;
        logic       tx_failed;
        logic [3:0] descriptor_antenna_field;
        logic [3:0] last_tx_antenna_in;
        logic       rx_start;
        logic       rx_done;
        logic       response_done;
        logic       expect_cts;
    } mac_event_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } reg_req_type;

    typedef struct packed {
        logic second_attenuator_out;
        logic first_attenuator_out;
        logic antenna_select_d;
        logic antenna_select_c;
        logic antenna_select_b;
        logic antenna_select_a;
    } switch_pins_type;
endpackage : antenna_pkg
`default_nettype wire

// ### rtl/switch_table_lookup.sv
// Switch table entry selection from chip state, antenna and attenuation controls
`default_nettype none
module switch_table_lookup
    import antenna_pkg::*;
(
    input  wire logic [31:0] idle_word,       // Idle control register
    input  wire logic [31:0] table_one,       // Antenna one table
    input  wire logic [31:0] table_two,       // Antenna two table
    input  wire logic        is_idle,         // Chip idle
    input  wire logic        is_tx,           // Chip transmitting
    input  wire logic        ant_two,         // Antenna two selected
    input  wire logic        atten_first,     // First stage attenuation
    input  wire logic        atten_second,    // Second stage attenuation
    output logic      [5:0]  entry            // Selected six bit entry
);
    logic [31:0] word;
    int          slot;

    always_comb begin
        word = ant_two ? table_two : table_one;
        if (is_tx) begin
            slot = slot_tx;
        end else if (atten_first && atten_second) begin
            slot = slot_rx_both;
        end else if (atten_second) begin
            slot = slot_rx_second;
        end else if (atten_first) begin
            slot = slot_rx_first;
        end else begin
            slot = slot_rx_plain;
        end
        if (is_idle) begin
            entry = idle_word[idle_entry_lsb +: entry_width];
        end else begin
            entry = word[slot*entry_width +: entry_width];
        end
    end
endmodule : switch_table_lookup
`default_nettype wire

// ### rtl/antenna_select_switch.sv
// Antenna selection and antenna switch pin driver
//
// Overview of operation
// - Listen and send ACK on default antenna
// - Hold transmit antenna while awaiting ACK
// - Receive CTS on following data antenna
// - Four-bit default antenna picks rx/tx antenna
// - Zero descriptor: key cache or default LSB
// - Update bit rewrites default after each non-ACK transmit
// - RTS on default when bit set
// - Omni AP: key-cache antenna, toggle every second failure
// - Omni STA records last antenna in default
// - Sectored AP: descriptor selects, omni listens
// - Eleven six-bit entries indexed by state
// - 2.4 GHz baseband may override antenna after detection
// - Entry bits map to six output pins
// - Idle and per-antenna table register layout
// - 5 GHz never enables second attenuation
// - 2.4 GHz enables stages as strength rises
// - Reset gives listen state, zero pins, default antenna one
`default_nettype none
module antenna_select_switch
    import antenna_pkg::*;
(
    input  wire logic           core_clk,             // Core clock
    input  wire logic           rstn,                 // Async reset, active low
    input  wire reg_req_type    reg_req,              // Register access request
    output logic      [31:0]    reg_rdata,            // Register read data
    input  wire logic [3:0]     default_antenna_field, // Software write value of default
    input  wire logic           default_antenna_wr,   // Software write strobe of default
    input  wire mode_bits_type  mode_bits,            // Station config word bits
    input  wire mac_event_type  mac_event,            // Frame sequence events
    input  wire logic           chip_active,          // Transceiver out of idle
    input  wire logic           rssi_above_first,     // Strength past first threshold
    input  wire logic           rssi_above_second,    // Strength past second threshold
    input  wire logic           packet_detected,      // Baseband packet detection
    input  wire logic [3:0]     diversity_antenna,    // Baseband preferred antenna
    output logic      [3:0]     default_antenna_register, // Current default antenna
    output logic      [3:0]     last_tx_antenna_out,  // Antenna to store in key cache
    output logic                last_tx_antenna_wr,   // Key cache store strobe
    output logic      [3:0]     selected_antenna,     // Antenna chosen by the MAC
    output switch_pins_type     switch_pins           // Six antenna and attenuator pins
);
    typedef struct packed {
        seq_state_type   state;
        logic [31:0]     idle_control;
        logic [31:0]     table_one;
        logic [31:0]     table_two;
        logic [31:0]     rdata;
        logic [3:0]      default_antenna;
        logic [3:0]      locked_antenna;
        logic [3:0]      selected;
        logic [3:0]      key_antenna;
        logic            key_wr;
        logic            fail_parity;
        logic            override_active;
        logic [3:0]      override_antenna;
        switch_pins_type pins;
    } state_type;

    state_type cur_reg;
    state_type cur_next;
    logic      rst_meta_reg;
    logic      rst_sync_reg;
    logic [5:0] entry;

    function automatic logic [3:0] toggle_antenna(input logic [3:0] ant);
        toggle_antenna = (ant == antenna_two) ? antenna_one : antenna_two;
    endfunction : toggle_antenna

    // Transmit antenna for a data frame
    function automatic logic [3:0] data_antenna(input mac_event_type ev,
                                                input mode_bits_type mb,
                                                input logic [3:0] def_ant);
        if (ev.descriptor_antenna_field != 4'h0) begin
            data_antenna = ev.descriptor_antenna_field;
        end else if (mb.use_default_antenna) begin
            data_antenna = {3'h0, def_ant[0]} == 4'h0 ? antenna_two : antenna_one;
        end else begin
            data_antenna = ev.last_tx_antenna_in;
        end
    endfunction : data_antenna

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    switch_table_lookup lookup (
        .idle_word    (cur_reg.idle_control),
        .table_one    (cur_reg.table_one),
        .table_two    (cur_reg.table_two),
        .is_idle      (!chip_active),
        .is_tx        (cur_reg.state == st_tx),
        .ant_two      (cur_reg.selected == antenna_two),
        .atten_first  (rssi_above_first),
        .atten_second (mode_bits.band_2g && rssi_above_second),
        .entry        (entry)
    );

    always_comb begin
        logic [3:0] tx_ant;
        tx_ant = 4'h0;
        cur_next = cur_reg;
        cur_next.key_wr = 1'b0;

        // Register port
        if (reg_req.wr) begin
            if (reg_req.addr == idle_control_offset) begin
                cur_next.idle_control = reg_req.wdata;
            end else if (reg_req.addr == table_one_offset) begin
                cur_next.table_one = reg_req.wdata;
            end else if (reg_req.addr == table_two_offset) begin
                cur_next.table_two = reg_req.wdata;
            end
        end
        if (reg_req.rd) begin
            if (reg_req.addr == idle_control_offset) begin
                cur_next.rdata = cur_reg.idle_control;
            end else if (reg_req.addr == table_one_offset) begin
                cur_next.rdata = cur_reg.table_one;
            end else if (reg_req.addr == table_two_offset) begin
                cur_next.rdata = cur_reg.table_two;
            end else begin
                cur_next.rdata = 32'h0000_0000;
            end
        end
        if (default_antenna_wr) begin
            cur_next.default_antenna = default_antenna_field;
        end

        case (cur_reg.state)
            st_listen: begin
                cur_next.selected = cur_reg.default_antenna;
                if (mac_event.tx_start) begin
                    if (mac_event.tx_is_ack) begin
                        tx_ant = cur_reg.default_antenna;
                    end else if (mac_event.tx_is_rts && mode_bits.rts_on_default) begin
                        tx_ant = cur_reg.default_antenna;
                    end else begin
                        tx_ant = data_antenna(mac_event, mode_bits, cur_reg.default_antenna);
                    end
                    cur_next.selected = tx_ant;
                    cur_next.locked_antenna = mac_event.tx_is_rts ?
                        data_antenna(mac_event, mode_bits, cur_reg.default_antenna) : tx_ant;
                    cur_next.state = st_tx;
                end else if (mac_event.rx_start) begin
                    cur_next.state = st_rx;
                end
            end
            st_tx: begin
                if (mac_event.tx_done) begin
                    if (!mac_event.tx_is_ack && mode_bits.update_default_antenna) begin
                        cur_next.default_antenna = cur_reg.selected;
                    end
                    if (!mac_event.tx_is_ack && !mode_bits.use_default_antenna &&
                        mac_event.descriptor_antenna_field == 4'h0) begin
                        cur_next.key_antenna = cur_reg.selected;
                        if (mac_event.tx_failed) begin
                            cur_next.fail_parity = !cur_reg.fail_parity;
                            if (cur_reg.fail_parity) begin
                                cur_next.key_antenna = toggle_antenna(cur_reg.selected);
                            end
                        end
                        cur_next.key_wr = 1'b1;
                    end
                    if (mac_event.tx_directed || mac_event.expect_cts) begin
                        cur_next.selected = cur_reg.locked_antenna;
                        cur_next.state = st_wait;
                    end else begin
                        cur_next.state = st_listen;
                    end
                end
            end
            st_wait: begin
                cur_next.selected = cur_reg.locked_antenna;
                if (mac_event.response_done) begin
                    cur_next.state = st_listen;
                end
            end
            st_rx: begin
                if (mode_bits.fast_diversity_enable && !mode_bits.band_2g) begin
                    cur_next.override_active = 1'b0;
                end else if (mode_bits.fast_diversity_enable && packet_detected) begin
                    cur_next.override_active = 1'b1;
                    cur_next.override_antenna = diversity_antenna;
                end
                cur_next.selected = cur_next.override_active ?
                    cur_next.override_antenna : cur_reg.default_antenna;
                if (mac_event.rx_done) begin
                    cur_next.override_active = 1'b0;
                    cur_next.state = st_listen;
                end
            end
            default: begin
                cur_next.state = st_listen;
            end
        endcase

        cur_next.pins = switch_pins_type'(entry);
    end

    always_ff @(posedge core_clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            cur_reg.state            <= st_listen;
            cur_reg.idle_control     <= idle_control_reset;
            cur_reg.table_one        <= table_reset;
            cur_reg.table_two        <= table_reset;
            cur_reg.rdata            <= 32'h0000_0000;
            cur_reg.default_antenna  <= default_antenna_reset;
            cur_reg.locked_antenna   <= omni_antenna;
            cur_reg.selected         <= omni_antenna;
            cur_reg.key_antenna      <= 4'h0;
            cur_reg.key_wr           <= 1'b0;
            cur_reg.fail_parity      <= 1'b0;
            cur_reg.override_active  <= 1'b0;
            cur_reg.override_antenna <= 4'h0;
            cur_reg.pins             <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign reg_rdata                = cur_reg.rdata;
    assign default_antenna_register = cur_reg.default_antenna;
    assign last_tx_antenna_out      = cur_reg.key_antenna;
    assign last_tx_antenna_wr       = cur_reg.key_wr;
    assign selected_antenna         = cur_reg.selected;
    assign switch_pins              = cur_reg.pins;
endmodule : antenna_select_switch
`default_nettype wire

// ### sim/rf_switch_model.sv
// Model of the external antenna switches and attenuators
`default_nettype none
module rf_switch_model
    import antenna_pkg::*;
(
    input  wire switch_pins_type pins,    // Pins from the block
    output logic [3:0]           ant_sel, // Switch lines d to a
    output logic [1:0]           atten    // Second and first attenuator
);
    timeunit 1ns;
    timeprecision 1ns;
    assign ant_sel = {pins.antenna_select_d, pins.antenna_select_c,
                      pins.antenna_select_b, pins.antenna_select_a};
    assign atten = {pins.second_attenuator_out, pins.first_attenuator_out};
endmodule : rf_switch_model
`default_nettype wire

// ### sim/antenna_properties.sv
// Port checks for the antenna select and switch block
`default_nettype none
module antenna_checker
    import antenna_pkg::*;
(
    input wire logic            core_clk,                 // Clock
    input wire logic            rstn,                     // Reset
    input wire reg_req_type     reg_req,                  // Register request
    input wire logic [31:0]     reg_rdata,                // Read data
    input wire logic            default_antenna_wr,       // Default write
    input wire logic [3:0]      default_antenna_field,    // Default value
    input wire mode_bits_type   mode_bits,                // Mode bits
    input wire mac_event_type   mac_event,                // Events
    input wire logic            chip_active,              // Not idle
    input wire logic [3:0]      default_antenna_register, // Default antenna
    input wire logic            last_tx_antenna_wr,       // Key store
    input wire logic [3:0]      selected_antenna,         // Chosen antenna
    input wire switch_pins_type switch_pins,              // Pins
    input wire logic            packet_detected           // Baseband detection
);
    logic [31:0] sh_idle, sh_one, sh_two, rd_exp;
    logic        quiet;
    logic        reset_held_reg;
    // Skips the first edge of reset, before the design has seen it
    always_ff @(posedge core_clk) begin
        reset_held_reg <= !rstn;
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sh_idle <= idle_control_reset;
            sh_one <= table_reset;
            sh_two <= table_reset;
        end else if (reg_req.wr) begin
            sh_idle <= (reg_req.addr == idle_control_offset) ? reg_req.wdata : sh_idle;
            sh_one <= (reg_req.addr == table_one_offset) ? reg_req.wdata : sh_one;
            sh_two <= (reg_req.addr == table_two_offset) ? reg_req.wdata : sh_two;
        end
    end
    always_comb begin
        case (reg_req.addr)
            idle_control_offset: rd_exp = sh_idle;
            table_one_offset:    rd_exp = sh_one;
            table_two_offset:    rd_exp = sh_two;
            default:             rd_exp = 32'h0;
        endcase
    end
    assign quiet = !(mac_event.tx_start || mac_event.tx_done || mac_event.rx_start
                     || mac_event.rx_done || mac_event.response_done || default_antenna_wr
                     || packet_detected);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    property p_reset_state;
        disable iff (1'b0) !rstn && reset_held_reg
            |-> switch_pins == 6'h0 && default_antenna_register == 4'h1;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");
    property p_read_data;
        reg_req.rd |=> reg_rdata == $past(rd_exp);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data wrong");
    property p_read_hold;
        !reg_req.rd |=> $stable(reg_rdata);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data moved");
    property p_idle_pins;
        (!chip_active && !reg_req.wr)[*3] |-> switch_pins == sh_idle[9:4];
    endproperty
    a_idle_pins: assert property (p_idle_pins) else $error("idle pins wrong");
    property p_key_pulse;
        last_tx_antenna_wr |-> $past(mac_event.tx_done) ##1 !last_tx_antenna_wr;
    endproperty
    a_key_pulse: assert property (p_key_pulse) else $error("key store pulse wrong");
    property p_sel_steady;
        quiet[*3] |-> $stable(selected_antenna);
    endproperty
    a_sel_steady: assert property (p_sel_steady) else $error("antenna moved");
    property p_def_kept;
        !mode_bits.update_default_antenna && !default_antenna_wr
            |=> $stable(default_antenna_register);
    endproperty
    a_def_kept: assert property (p_def_kept) else $error("default changed");
    property p_def_write;
        default_antenna_wr |=> default_antenna_register == $past(default_antenna_field);
    endproperty
    a_def_write: assert property (p_def_write) else $error("default write lost");
    property p_ack_lock;
        mac_event.tx_done && mac_event.tx_directed ##1 !mac_event.response_done
            |-> $stable(selected_antenna);
    endproperty
    a_ack_lock: assert property (p_ack_lock) else $error("antenna left during wait");
    c_tx: cover property (mac_event.tx_start ##3 mac_event.tx_done);
    c_key: cover property (last_tx_antenna_wr);
    c_read: cover property (reg_req.rd);
endmodule : antenna_checker
bind antenna_select_switch antenna_checker i_chk (.core_clk, .rstn, .reg_req, .reg_rdata,
    .default_antenna_wr, .default_antenna_field, .mode_bits, .mac_event, .chip_active,
    .default_antenna_register, .last_tx_antenna_wr, .selected_antenna, .switch_pins,
    .packet_detected);
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench of the antenna select and switch block
`default_nettype none
module testbench
    import antenna_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rstn = 1'b0, def_wr, chip_active, rssi1, rssi2, pkt_det, key_wr;
    logic [3:0] def_field, div_ant, def_reg, key_ant, sel_ant, ant_sel;
    logic [1:0] atten;
    logic [31:0] reg_rdata, m_idle, m_tab[1:2];
    logic [15:0] addrs[4] = '{idle_control_offset, table_one_offset, table_two_offset, 16'h9914};
    reg_req_type reg_req;
    mode_bits_type mode;
    mac_event_type ev;
    switch_pins_type pins;
    int num_errors = 0, checks_done = 0, cycles = 0;
    integer seed = 32'he985c8a9;
    antenna_select_switch i_dut (.core_clk, .rstn, .reg_req, .reg_rdata,
        .default_antenna_field(def_field), .default_antenna_wr(def_wr), .mode_bits(mode),
        .mac_event(ev), .chip_active, .rssi_above_first(rssi1), .rssi_above_second(rssi2),
        .packet_detected(pkt_det), .diversity_antenna(div_ant), .default_antenna_register(def_reg),
        .last_tx_antenna_out(key_ant), .last_tx_antenna_wr(key_wr), .selected_antenna(sel_ant),
        .switch_pins(pins));
    rf_switch_model i_rf (.pins, .ant_sel, .atten);
    always #25 core_clk = ~core_clk;
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            $display("Error at %0t: run hung", $time);
            report_and_stop();
        end
    end
    task automatic tick(int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [5:0] exp_pins(int st, int ant);
        int   slot;
        logic s2;
        s2 = rssi2 && mode.band_2g;
        slot = (st == 1) ? 0 : rssi1 ? (s2 ? 4 : 2) : (s2 ? 3 : 1);
        return (st == 0) ? m_idle[9:4] : m_tab[ant][slot*6 +: 6];
    endfunction : exp_pins
    task automatic chk_pins(int st, int ant);
        chk(32'({atten, ant_sel}), 32'(exp_pins(st, ant)));
    endtask : chk_pins
    task automatic wr_reg(logic [15:0] a, logic [31:0] d);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick();
        reg_req.wr = 1'b0;
        if (a == idle_control_offset) m_idle = d;
        if (a == table_one_offset) m_tab[1] = d;
        if (a == table_two_offset) m_tab[2] = d;
        tick();
    endtask : wr_reg
    task automatic rd_reg(logic [15:0] a);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        tick();
        reg_req.rd = 1'b0;
        chk(reg_rdata, (a == idle_control_offset) ? m_idle : (a == table_one_offset) ? m_tab[1]
            : (a == table_two_offset) ? m_tab[2] : 32'h0);
        tick();
    endtask : rd_reg
    task automatic pulse(int k);
        {ev.tx_start, ev.tx_done, ev.response_done} = {k == 0, k == 1, k == 2};
        {ev.rx_start, ev.rx_done, def_wr} = {k == 3, k == 4, k == 5};
        tick();
        {ev.tx_start, ev.tx_done, ev.response_done, ev.rx_start, ev.rx_done, def_wr} = '0;
    endtask : pulse
    initial begin
        {reg_req, ev, mode, def_field, def_wr, chip_active, rssi1, rssi2, pkt_det, div_ant} = '0;
        {m_idle, m_tab[1], m_tab[2]} = '0;
        tick(5);
        rstn = 1'b1;
        tick(3);
        chk_pins(0, 1);
        chk(32'(def_reg), 32'(default_antenna_reset));
        chk(32'(sel_ant), 32'(antenna_one));
        foreach (addrs[i]) rd_reg(addrs[i]);
        foreach (addrs[i]) wr_reg(addrs[i], $random(seed));
        foreach (addrs[i]) rd_reg(addrs[i]);
        tick(2);
        chk_pins(0, 1);
        rd_reg(idle_control_offset);
        wr_reg(idle_control_offset, {reg_rdata[31:10], 6'h2d, reg_rdata[3:0]});
        tick(2);
        chk_pins(0, 1);
        $display("Test registers and idle done");
        def_field = antenna_two;
        pulse(5);
        tick();
        chip_active = 1'b1;
        pulse(3);
        for (int b = 0; b < 2; b++) begin
            for (int k = 0; k < 3; k++) begin
                {mode.band_2g, rssi1, rssi2} = {b == 1, k > 0, k > 1};
                tick(2);
                chk(32'(sel_ant), 32'(antenna_two));
                chk_pins(2, 2);
            end
        end
        {mode.fast_diversity_enable, pkt_det, div_ant} = {1'b1, 1'b1, antenna_one};
        tick(2);
        chk(32'(sel_ant), 32'(antenna_one));
        {mode.fast_diversity_enable, pkt_det} = 2'b00;
        pulse(4);
        {rssi1, rssi2, ev.descriptor_antenna_field, ev.tx_directed} = {2'b00, antenna_one, 1'b1};
        $display("Test listening done");
        tick();
        pulse(0);
        tick(2);
        chk(32'(sel_ant), 32'(antenna_one));
        chk_pins(1, 1);
        pulse(1);
        tick(2);
        chk(32'(sel_ant), 32'(antenna_one));
        chk_pins(2, 1);
        pulse(2);
        tick(2);
        chk(32'(sel_ant), 32'(antenna_two));
        {ev.tx_directed, ev.tx_is_rts, ev.expect_cts} = 3'b011;
        for (int r = 0; r < 2; r++) begin
            mode.rts_on_default = (r == 1);
            pulse(0);
            tick(2);
            chk(32'(sel_ant), (r == 1) ? 32'(antenna_two) : 32'(antenna_one));
            pulse(1);
            tick(2);
            chk(32'(sel_ant), 32'(antenna_one));
            pulse(2);
            tick(2);
        end
        {ev.tx_is_rts, ev.expect_cts, mode.rts_on_default} = '0;
        {ev.descriptor_antenna_field, ev.last_tx_antenna_in} = {4'h0, antenna_one};
        $display("Test sectored and rts done");
        for (int u = 0; u < 2; u++) begin
            mode.update_default_antenna = (u == 1);
            pulse(0);
            tick(2);
            chk(32'(sel_ant), 32'(antenna_one));
            pulse(1);
            if (u == 0) chk(32'({key_wr, key_ant}), 32'({1'b1, antenna_one}));
            tick(2);
            chk(32'(def_reg), (u == 1) ? 32'(antenna_one) : 32'(antenna_two));
        end
        ev.tx_failed = 1'b1;
        for (int f = 0; f < 2; f++) begin
            pulse(0);
            tick(2);
            pulse(1);
            chk(32'({key_wr, key_ant}), 32'({1'b1, f ? antenna_two : antenna_one}));
            tick(2);
        end
        ev.tx_failed = 1'b0;
        {mode.use_default_antenna, mode.update_default_antenna} = 2'b10;
        ev.last_tx_antenna_in = antenna_two;
        pulse(0);
        tick(2);
        chk(32'(sel_ant), 32'(antenna_one));
        pulse(1);
        tick(2);
        $display("Test omni modes done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
